// >>> rtl/pmdpc_top.sv
// PLL mode decode, divider path routing and APB control registers
`default_nettype none
`include "pmdpc_cfg.svh"
module pmdpc_top
  import pmdpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_tick,
  input wire logic vcxo_tick,
  input wire logic vco_int_tick,
  input wire logic vco_ext_tick,
  input wire logic input_absent_detect,
  input wire logic pll0_lock_raw,
  input wire logic pll1_lock_raw,
  output logic chan_tick,
  output logic delay_tbase_tick,
  output logic pll0_fb_tick,
  output logic pll0_enable,
  output logic pll1_enable,
  output logic doubler_active,
  output logic pll1_ref_from_input,
  output logic [1:0] input_choice,
  output logic auto_switch_enable,
  output logic holdover_enable,
  output logic input_absent_valid,
  output logic input_absent,
  output logic vcxo_center_hold,
  output logic [4:0] first_loop_pump_current,
  output logic first_loop_pump_step_200,
  output logic first_loop_pump_sink_enable,
  output logic [3:0] first_loop_pump_offset,
  output logic pll0_lock,
  output logic pll1_lock
);

  pmdpc_top_s s_reg;
  pmdpc_top_s s_next;

  logic rn_tick;
  logic p1_tick;
  logic m1_tick;
  logic m0_tick;
  logic vco_eff;
  logic vcxo_fb;
  logic m0_in;
  logic wr_en;
  logic setup;
  logic known;
  logic [31:0] rd_data;
  logic [4:0] pump_max;
  logic [4:0] pump_wr;
  logic lock0_next;
  logic [3:0] rn_ratio;

  ////////////////////////////////////////////////////////////////////////
  // Divider chain

  assign rn_ratio = 4'h1 << s_reg.rn;

  pmdpc_pulse_div #(.W(4)) u_rn_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(ref_tick),
    .ratio(rn_ratio),
    .tick_out(rn_tick)
  );

  pmdpc_pulse_div #(.W(7)) u_p1_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(rn_tick),
    .ratio(s_reg.p1),
    .tick_out(p1_tick)
  );

  pmdpc_pulse_div #(.W(14)) u_m1_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(vco_eff),
    .ratio(s_reg.m1),
    .tick_out(m1_tick)
  );

  pmdpc_pulse_div #(.W(15)) u_m0_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(m0_in),
    .ratio(s_reg.m0),
    .tick_out(m0_tick)
  );

  pmdpc_chan_div u_chan_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(s_reg.origin_tick),
    .k(s_reg.k),
    .m(s_reg.m),
    .tick_out(chan_tick)
  );

  always_comb begin
    vco_eff = (s_reg.src == 2'h1) ? vco_ext_tick : vco_int_tick;
    // Optional halving of the selected VCO, internal or external
    vco_eff = vco_eff & (!s_reg.vco_halve | s_reg.vco_tog);
    vcxo_fb = vcxo_tick & (!s_reg.halve | s_reg.fb_tog);
    m0_in = s_reg.route ? m1_tick : vcxo_fb;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register access and mode decode

  assign setup = psel & !penable & !s_reg.pready;
  assign wr_en = psel & penable & s_reg.pready & pwrite;
  assign known = (paddr == `PMDPC_OFF_MODE) || (paddr == `PMDPC_OFF_FBDIV0)
    || (paddr == `PMDPC_OFF_FBDIV1) || (paddr == `PMDPC_OFF_PRESC)
    || (paddr == `PMDPC_OFF_CHDIV) || (paddr == `PMDPC_OFF_PUMP)
    || (paddr == `PMDPC_OFF_STATUS);
  assign pump_wr = pwdata[`PMDPC_PUMP_CODE_LSB +: 5];
  assign pump_max = pwdata[`PMDPC_PUMP_STEP] ? 5'(`PMDPC_PUMP_MAX_HI)
    : 5'(`PMDPC_PUMP_MAX_LO);

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (paddr)
      `PMDPC_OFF_MODE: begin
        rd_data[`PMDPC_MODE_SRC_LSB +: 2] = s_reg.src;
        rd_data[`PMDPC_MODE_BYP] = s_reg.byp;
        rd_data[`PMDPC_MODE_FD] = s_reg.fd;
        rd_data[`PMDPC_MODE_HALVE] = s_reg.halve;
        rd_data[`PMDPC_MODE_ROUTE] = s_reg.route;
        rd_data[`PMDPC_MODE_HOLD] = s_reg.hold;
        rd_data[`PMDPC_MODE_SUPP] = s_reg.supp;
        rd_data[`PMDPC_MODE_INSEL_LSB +: 2] = s_reg.insel;
        rd_data[`PMDPC_MODE_VCOH] = s_reg.vco_halve;
      end
      `PMDPC_OFF_FBDIV0: rd_data[14:0] = s_reg.m0;
      `PMDPC_OFF_FBDIV1: rd_data[13:0] = s_reg.m1;
      `PMDPC_OFF_PRESC: begin
        rd_data[`PMDPC_PRESC_RN_LSB +: 2] = s_reg.rn;
        rd_data[`PMDPC_PRESC_P1_LSB +: 7] = s_reg.p1;
      end
      `PMDPC_OFF_CHDIV: begin
        rd_data[`PMDPC_CHDIV_K_LSB +: 3] = s_reg.k;
        rd_data[`PMDPC_CHDIV_M_LSB +: 4] = s_reg.m;
      end
      `PMDPC_OFF_PUMP: begin
        rd_data[`PMDPC_PUMP_CODE_LSB +: 5] = s_reg.pump;
        rd_data[`PMDPC_PUMP_STEP] = s_reg.step200;
        rd_data[`PMDPC_PUMP_SINK] = s_reg.sink;
        rd_data[`PMDPC_PUMP_OFF_LSB +: 4] = s_reg.poff;
      end
      `PMDPC_OFF_STATUS: begin
        rd_data[`PMDPC_ST_MODE_LSB +: 2] = s_reg.mode;
        rd_data[`PMDPC_ST_PLL0_EN] = s_reg.pll0_en;
        rd_data[`PMDPC_ST_PLL1_EN] = s_reg.pll1_en;
        rd_data[`PMDPC_ST_LOS_VALID] = s_reg.los_valid;
        rd_data[`PMDPC_ST_AUTOSW] = s_reg.autosw;
        rd_data[`PMDPC_ST_HOLDOVER] = s_reg.holdover;
        rd_data[`PMDPC_ST_PLL0_LOCK] = s_reg.pll0_lock;
        rd_data[`PMDPC_ST_PLL1_LOCK] = s_reg.pll1_lock;
        rd_data[`PMDPC_ST_LOL] = s_reg.lol;
        rd_data[`PMDPC_ST_ABSENT] = s_reg.in_absent;
        rd_data[`PMDPC_ST_CFG_ERR] = s_reg.cfg_err;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    if (setup) begin
      // Answer is prepared in setup so access phase ends in one cycle
      s_next.pready = 1'b1;
      s_next.pslverr = !known;
      s_next.prdata = (known && !pwrite) ? rd_data : 32'h0000_0000;
    end
    if (wr_en) begin
      unique case (paddr)
        `PMDPC_OFF_MODE: begin
          s_next.src = pwdata[`PMDPC_MODE_SRC_LSB +: 2];
          s_next.byp = pwdata[`PMDPC_MODE_BYP];
          s_next.fd = pwdata[`PMDPC_MODE_FD];
          s_next.halve = pwdata[`PMDPC_MODE_HALVE];
          s_next.route = pwdata[`PMDPC_MODE_ROUTE];
          s_next.hold = pwdata[`PMDPC_MODE_HOLD];
          s_next.supp = pwdata[`PMDPC_MODE_SUPP];
          s_next.insel = pwdata[`PMDPC_MODE_INSEL_LSB +: 2];
          s_next.vco_halve = pwdata[`PMDPC_MODE_VCOH];
        end
        `PMDPC_OFF_FBDIV0: s_next.m0 = pwdata[14:0];
        `PMDPC_OFF_FBDIV1: s_next.m1 = pwdata[13:0];
        `PMDPC_OFF_PRESC: begin
          s_next.rn = pwdata[`PMDPC_PRESC_RN_LSB +: 2];
          s_next.p1 = pwdata[`PMDPC_PRESC_P1_LSB +: 7];
        end
        `PMDPC_OFF_CHDIV: begin
          s_next.k = pwdata[`PMDPC_CHDIV_K_LSB +: 3];
          s_next.m = pwdata[`PMDPC_CHDIV_M_LSB +: 4];
        end
        `PMDPC_OFF_PUMP: begin
          // Clamp keeps the pump at or below its top current
          s_next.pump = (pump_wr > pump_max) ? pump_max : pump_wr;
          s_next.step200 = pwdata[`PMDPC_PUMP_STEP];
          s_next.sink = pwdata[`PMDPC_PUMP_SINK];
          s_next.poff = pwdata[`PMDPC_PUMP_OFF_LSB +: 4];
        end
        `PMDPC_OFF_STATUS: begin
          if (pwdata[`PMDPC_ST_LOL]) begin
            s_next.lol = 1'b0;
          end
        end
        default: s_next.lol = s_reg.lol;
      endcase
    end

    // Decode follows live bits, no reset needed to change mode
    if (s_reg.src == 2'h3) begin
      s_next.mode = PMDPC_BYPASS;
    end else if (s_reg.src == 2'h2) begin
      s_next.mode = PMDPC_VCXO;
    end else if (s_reg.byp) begin
      s_next.mode = PMDPC_SYNTH;
    end else begin
      s_next.mode = PMDPC_DUAL;
    end
    s_next.cfg_err = (s_reg.src == 2'h3) & (!s_reg.byp | s_reg.fd);
    s_next.pll0_en = (s_next.mode == PMDPC_DUAL)
      || (s_next.mode == PMDPC_VCXO);
    s_next.pll1_en = (s_next.mode == PMDPC_DUAL)
      || (s_next.mode == PMDPC_SYNTH);
    s_next.dbl_act = s_reg.fd & s_next.pll1_en;
    s_next.pll1_from_in = s_next.mode == PMDPC_SYNTH;
    s_next.los_valid = (s_next.mode != PMDPC_BYPASS) & !s_reg.supp;
    s_next.in_absent = input_absent_detect & s_next.los_valid;
    s_next.autosw = s_next.pll0_en & !s_reg.supp;
    s_next.holdover = s_next.pll0_en;

    // Centre hold forces the first loop out of lock
    lock0_next = pll0_lock_raw & s_next.pll0_en & !s_reg.hold;
    s_next.pll0_lock = lock0_next;
    s_next.pll1_lock = pll1_lock_raw & s_next.pll1_en;
    // Set after the clear so a coincident loss is never dropped
    if ((s_reg.pll0_lock && !lock0_next)
        || (s_reg.hold && s_next.pll0_en)) begin
      s_next.lol = 1'b1;
    end

    if (vcxo_tick) begin
      s_next.fb_tog = !s_reg.fb_tog;
    end
    if ((s_reg.src == 2'h1) ? vco_ext_tick : vco_int_tick) begin
      s_next.vco_tog = !s_reg.vco_tog;
    end
    unique case (s_reg.src)
      2'h0, 2'h1: s_next.origin_tick = vco_eff;
      2'h2: s_next.origin_tick = vcxo_tick;
      2'h3: s_next.origin_tick = p1_tick;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.src <= `PMDPC_RST_SRC;
      s_reg.hold <= `PMDPC_RST_HOLD;
      s_reg.m0 <= `PMDPC_RST_M0;
      s_reg.m1 <= `PMDPC_RST_M1;
      s_reg.rn <= `PMDPC_RST_RN;
      s_reg.p1 <= `PMDPC_RST_P1;
      s_reg.k <= `PMDPC_RST_K;
      s_reg.m <= `PMDPC_RST_M;
      s_reg.mode <= PMDPC_DUAL;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign delay_tbase_tick = s_reg.origin_tick;
  assign pll0_fb_tick = m0_tick;
  assign pll0_enable = s_reg.pll0_en;
  assign pll1_enable = s_reg.pll1_en;
  assign doubler_active = s_reg.dbl_act;
  assign pll1_ref_from_input = s_reg.pll1_from_in;
  assign input_choice = s_reg.insel;
  assign auto_switch_enable = s_reg.autosw;
  assign holdover_enable = s_reg.holdover;
  assign input_absent_valid = s_reg.los_valid;
  assign input_absent = s_reg.in_absent;
  assign vcxo_center_hold = s_reg.hold;
  assign first_loop_pump_current = s_reg.pump;
  assign first_loop_pump_step_200 = s_reg.step200;
  assign first_loop_pump_sink_enable = s_reg.sink;
  assign first_loop_pump_offset = s_reg.poff;
  assign pll0_lock = s_reg.pll0_lock;
  assign pll1_lock = s_reg.pll1_lock;

endmodule
`default_nettype wire

// >>> shared/pmdpc_cfg.svh
// Register offsets, field positions, reset values for the PLL path control
`ifndef PMDPC_CFG_SVH
`define PMDPC_CFG_SVH

`define PMDPC_OFF_MODE 8'h00
`define PMDPC_OFF_FBDIV0 8'h04
`define PMDPC_OFF_FBDIV1 8'h08
`define PMDPC_OFF_PRESC 8'h0C
`define PMDPC_OFF_CHDIV 8'h10
`define PMDPC_OFF_PUMP 8'h14
`define PMDPC_OFF_STATUS 8'h18

// Mode control fields
`define PMDPC_MODE_SRC_LSB 0
`define PMDPC_MODE_BYP 2
`define PMDPC_MODE_FD 3
`define PMDPC_MODE_HALVE 4
`define PMDPC_MODE_ROUTE 5
`define PMDPC_MODE_HOLD 6
`define PMDPC_MODE_SUPP 7
`define PMDPC_MODE_INSEL_LSB 8
`define PMDPC_MODE_VCOH 10

// Prescaler fields
`define PMDPC_PRESC_RN_LSB 0
`define PMDPC_PRESC_P1_LSB 8

// Channel divider fields
`define PMDPC_CHDIV_K_LSB 0
`define PMDPC_CHDIV_M_LSB 4
`define PMDPC_CHDIV_K_MAX 3'h5
`define PMDPC_CHDIV_M_MAX 4'hC

// Charge pump fields
`define PMDPC_PUMP_CODE_LSB 0
`define PMDPC_PUMP_STEP 5
`define PMDPC_PUMP_SINK 6
`define PMDPC_PUMP_OFF_LSB 8
`define PMDPC_PUMP_MAX_UA 3000
`define PMDPC_PUMP_STEP_LO_UA 100
`define PMDPC_PUMP_STEP_HI_UA 200
`define PMDPC_PUMP_MAX_LO (`PMDPC_PUMP_MAX_UA / `PMDPC_PUMP_STEP_LO_UA)
`define PMDPC_PUMP_MAX_HI (`PMDPC_PUMP_MAX_UA / `PMDPC_PUMP_STEP_HI_UA)

// Status fields
`define PMDPC_ST_MODE_LSB 0
`define PMDPC_ST_PLL0_EN 2
`define PMDPC_ST_PLL1_EN 3
`define PMDPC_ST_LOS_VALID 4
`define PMDPC_ST_AUTOSW 5
`define PMDPC_ST_HOLDOVER 6
`define PMDPC_ST_PLL0_LOCK 7
`define PMDPC_ST_PLL1_LOCK 8
`define PMDPC_ST_LOL 9
`define PMDPC_ST_ABSENT 10
`define PMDPC_ST_CFG_ERR 11

// Reset values
`define PMDPC_RST_SRC 2'h0
`define PMDPC_RST_HOLD 1'h1
`define PMDPC_RST_M0 15'h0001
`define PMDPC_RST_M1 14'h0001
`define PMDPC_RST_RN 2'h0
`define PMDPC_RST_P1 7'h01
`define PMDPC_RST_K 3'h1
`define PMDPC_RST_M 4'h0

`endif

// >>> shared/pmdpc_pkg.sv
// Types shared by the PLL path control design
`default_nettype none
package pmdpc_pkg;

  typedef enum logic [1:0] {
    PMDPC_DUAL,
    PMDPC_SYNTH,
    PMDPC_VCXO,
    PMDPC_BYPASS
  } pmdpc_mode_e;

  typedef struct packed {
    logic [14:0] cnt;
    logic out;
  } pmdpc_div_s;

  typedef struct packed {
    logic [1:0] src;
    logic byp;
    logic fd;
    logic halve;
    logic route;
    logic hold;
    logic supp;
    logic [1:0] insel;
    logic vco_halve;
    logic [14:0] m0;
    logic [13:0] m1;
    logic [1:0] rn;
    logic [6:0] p1;
    logic [2:0] k;
    logic [3:0] m;
    logic [4:0] pump;
    logic step200;
    logic sink;
    logic [3:0] poff;
    logic fb_tog;
    logic vco_tog;
    logic origin_tick;
    pmdpc_mode_e mode;
    logic pll0_en;
    logic pll1_en;
    logic dbl_act;
    logic pll1_from_in;
    logic autosw;
    logic holdover;
    logic los_valid;
    logic in_absent;
    logic pll0_lock;
    logic pll1_lock;
    logic lol;
    logic cfg_err;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmdpc_top_s;

endpackage
`default_nettype wire

// >>> rtl/pmdpc_pulse_div.sv
// Integer divider of a tick stream, ratio zero treated as one
`default_nettype none
module pmdpc_pulse_div
  import pmdpc_pkg::*;
#(
  parameter int W = 15
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio,
  output logic tick_out
);

  pmdpc_div_s s_reg;
  pmdpc_div_s s_next;

  always_comb begin
    s_next = s_reg;
    s_next.out = 1'b0;
    if (tick_in) begin
      // Compare with >= so a shrinking ratio never strands the count
      if (ratio == '0 || s_reg.cnt[W-1:0] >= ratio - 1'b1) begin
        s_next.cnt = '0;
        s_next.out = 1'b1;
      end else begin
        s_next.cnt = 15'(s_reg.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_out = s_reg.out;

endmodule
`default_nettype wire

// >>> rtl/pmdpc_chan_div.sv
// Channel divider: ratio k times two to the m, k 1..5, m 0..12
`default_nettype none
`include "pmdpc_cfg.svh"
module pmdpc_chan_div
  import pmdpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic [2:0] k,
  input wire logic [3:0] m,
  output logic tick_out
);

  pmdpc_div_s s_reg;
  pmdpc_div_s s_next;
  logic [2:0] k_eff;
  logic [3:0] m_eff;
  logic [14:0] ratio;

  always_comb begin
    // Out-of-range fields clamp rather than alias
    k_eff = (k == 3'h0) ? 3'h1 : k;
    if (k > `PMDPC_CHDIV_K_MAX) begin
      k_eff = `PMDPC_CHDIV_K_MAX;
    end
    m_eff = (m > `PMDPC_CHDIV_M_MAX) ? `PMDPC_CHDIV_M_MAX : m;
    ratio = 15'(k_eff) << m_eff;
    s_next = s_reg;
    s_next.out = 1'b0;
    if (tick_in) begin
      if (s_reg.cnt >= ratio - 15'h0001) begin
        s_next.cnt = '0;
        s_next.out = 1'b1;
      end else begin
        s_next.cnt = 15'(s_reg.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick_out = s_reg.out;

endmodule
`default_nettype wire

// >>> bench/pmdpc_properties.sv
// Concurrent checks on the PLL path control ports
`default_nettype none
module pmdpc_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pready,
  input wire logic pll0_enable,
  input wire logic pll1_enable,
  input wire logic auto_switch_enable,
  input wire logic holdover_enable,
  input wire logic input_absent_valid,
  input wire logic vcxo_center_hold,
  input wire logic pll0_lock,
  input wire logic pll1_lock,
  input wire logic pll0_lock_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  property p_reset_state;
    disable iff (1'b0) !rst_n |=> vcxo_center_hold && !pready && !pll0_enable;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");
  // Lock updates in the same cycle as the decode, yet both cycles must be bypass
  property p_bypass_off;
    !pll0_enable && !pll1_enable && !$past(pll0_enable) && !$past(pll1_enable)
    |-> !auto_switch_enable && !input_absent_valid && !pll0_lock && !pll1_lock;
  endproperty
  a_bypass_off: assert property (p_bypass_off)
    else $error("bypass left a loop function on");
  property p_switch_needs_vcxo;
    auto_switch_enable |-> pll0_enable;
  endproperty
  a_switch_needs_vcxo: assert property (p_switch_needs_vcxo)
    else $error("switching without first loop");
  property p_holdover_needs_vcxo;
    holdover_enable |-> pll0_enable;
  endproperty
  a_holdover_needs_vcxo: assert property (p_holdover_needs_vcxo)
    else $error("holdover without first loop");
  property p_synth_no_holdover;
    pll1_enable && !pll0_enable |-> !holdover_enable;
  endproperty
  a_synth_no_holdover: assert property (p_synth_no_holdover)
    else $error("holdover in synthesizer mode");
  property p_suppress;
    auto_switch_enable |-> input_absent_valid;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("switching while absence invalid");
  property p_hold_unlocks;
    vcxo_center_hold && $past(vcxo_center_hold) |-> !pll0_lock;
  endproperty
  a_hold_unlocks: assert property (p_hold_unlocks)
    else $error("first loop locked under centre hold");
  property p_lock_from_raw;
    pll0_lock |-> $past(pll0_lock_raw);
  endproperty
  a_lock_from_raw: assert property (p_lock_from_raw)
    else $error("first loop lock without raw lock");
endmodule
`default_nettype wire

// >>> bench/pmdpc_clock_side.sv
// Far-side stand-in: reference, VCXO and VCO edge streams, raw locks
`default_nettype none
module pmdpc_clock_side (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] rgap,
  input wire logic [7:0] vgap,
  input wire logic lk,
  output logic ref_tick,
  output logic vcxo_tick,
  output logic vco_int_tick,
  output logic vco_ext_tick,
  output logic input_absent_detect,
  output logic pll0_lock_raw,
  output logic pll1_lock_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rc, vc;
  logic ph;
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rc <= 8'h00;
      vc <= 8'h00;
      ph <= 1'b0;
    end else begin
      rc <= (rc + 8'h01 >= rgap) ? 8'h00 : rc + 8'h01;
      vc <= (vc + 8'h01 >= vgap) ? 8'h00 : vc + 8'h01;
      ph <= ~ph;
    end
  end
  // A stopped reference is what the monitor flags as absent
  assign ref_tick = rgap != 8'h00 && rc == 8'h00;
  assign vcxo_tick = vgap != 8'h00 && vc == 8'h00;
  assign vco_int_tick = rst_n;
  assign vco_ext_tick = ph;
  assign input_absent_detect = rgap == 8'h00;
  assign pll0_lock_raw = lk;
  assign pll1_lock_raw = lk;
endmodule
`default_nettype wire

// >>> bench/pll_mode_divider_path_control_test.sv
// Self-checking bench for the PLL mode and divider path block
`default_nettype none
module pll_mode_divider_path_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, lk, e;
  logic [7:0] paddr, rgap, vgap;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, ref_tick, vcxo_tick, vco_int_tick, vco_ext_tick;
  logic input_absent_detect, pll0_lock_raw, pll1_lock_raw, chan_tick;
  logic delay_tbase_tick, pll0_fb_tick, pll0_enable, pll1_enable;
  logic doubler_active, pll1_ref_from_input, auto_switch_enable;
  logic holdover_enable, input_absent_valid, input_absent;
  logic vcxo_center_hold, first_loop_pump_step_200, pll0_lock, pll1_lock;
  logic first_loop_pump_sink_enable;
  logic [1:0] input_choice;
  logic [4:0] first_loop_pump_current;
  logic [3:0] first_loop_pump_offset;
  logic [2:0] tks;
  int mismatches, checks, cyc;
  assign tks = {pll0_fb_tick, delay_tbase_tick, chan_tick};
  pmdpc_top i_pmdpc_top (.*);
  pmdpc_clock_side i_pmdpc_clock_side (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // Answer taken at the rising edge that sees pready; only timeout ends it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // First interval after a change may be partial, so use the third
  task automatic per(input int b, input int x);
    int n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (tks[b] !== 1'b1 && n < 3000);
    end
    chk("tick period", n, x);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk("mode reg", rv, 32'h40);
    chk("hold pin", vcxo_center_hold, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("fb ratio", rv, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", rv, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_lock();
    @(posedge sys_clk);
    lk <= 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("held lock", pll0_lock, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    chk("loss flag", rv[9], 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(negedge sys_clk);
    chk("lock", {pll0_lock, pll1_lock}, 2'h3);
    $display("test lock done");
  endtask
  task automatic t_fb();
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h10, 32'h13);
    apb(1'b1, 8'h00, 32'h2);
    per(0, 18);
    per(1, 3);
    per(2, 15);
    apb(1'b1, 8'h00, 32'h12);
    per(2, 30);
    apb(1'b1, 8'h00, 32'h22);
    per(2, 10);
    $display("test feedback done");
  endtask
  task automatic t_mode();
    logic [11:0] mv [4] = '{12'h008, 12'h004, 12'h002, 12'h00F};
    logic [7:0] xv [4] = '{8'h1D, 8'h32, 8'h4C, 8'hE0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {20'h0, mv[i]});
      apb(1'b0, 8'h18, 32'h0);
      chk("decode",
          {rv[11], rv[1:0], pll1_enable, pll0_enable, holdover_enable,
          pll1_ref_from_input, doubler_active}, xv[i]);
    end
    $display("test modes done");
  endtask
  task automatic t_byp();
    apb(1'b1, 8'h00, 32'h207);
    apb(1'b1, 8'h0C, 32'h301);
    apb(1'b1, 8'h10, 32'h1);
    per(0, 12);
    chk("choice", input_choice, 2'h2);
    chk("bypass off",
        {pll0_enable, pll1_enable, auto_switch_enable, input_absent_valid,
        pll0_lock, pll1_lock}, 6'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk("cfg err", rv[11], 1'b0);
    apb(1'b1, 8'h0C, 32'h100);
    per(0, 2);
    // k of 7 must act as 5
    apb(1'b1, 8'h10, 32'h7);
    per(0, 10);
    $display("test bypass done");
  endtask
  task automatic t_supp();
    // Stopped reference, so the raw absence detector is high
    rgap <= 8'h00;
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h18, 32'h0);
    chk("suppressed",
        {auto_switch_enable, input_absent_valid, input_absent, rv[10],
        rv[5:4]}, 6'h00);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk("released",
        {auto_switch_enable, input_absent_valid, input_absent, rv[10]}, 4'hF);
    rgap <= 8'h02;
    $display("test suppress done");
  endtask
  task automatic t_pump();
    apb(1'b1, 8'h14, 32'h95F);
    apb(1'b0, 8'h14, 32'h0);
    chk("pump lo", rv, 32'h95E);
    chk("pump pins",
        {first_loop_pump_offset, first_loop_pump_sink_enable,
        first_loop_pump_step_200, first_loop_pump_current},
        {4'h9, 1'b1, 1'b0, 5'h1E});
    apb(1'b1, 8'h14, 32'h3F);
    apb(1'b0, 8'h14, 32'h0);
    chk("pump hi", rv, 32'h2F);
    $display("test pump done");
  endtask
  // Run last: large ratios would leave divider counters far from home
  task automatic t_limits();
    apb(1'b1, 8'h04, 32'hFFFF_FFFF);
    apb(1'b0, 8'h04, 32'h0);
    chk("m0 width", rv, 32'h7FFF);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    apb(1'b0, 8'h08, 32'h0);
    chk("m1 width", rv, 32'h3FFF);
    apb(1'b1, 8'h10, 32'hFF);
    apb(1'b0, 8'h10, 32'h0);
    // Fields are stored as written; the clamp acts inside the divider
    chk("chdiv fields", rv, 32'hF7);
    $display("test limits done");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lk = 1'b0;
    rgap = 8'h02;
    vgap = 8'h03;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_fb();
    t_mode();
    t_byp();
    t_supp();
    t_pump();
    t_limits();
    print_verdict();
  end
endmodule
bind pmdpc_top pmdpc_properties i_pmdpc_properties (.*);
`default_nettype wire
